// *** rtl/gcrd_pkg.sv ***
// Purpose: constants shared by the ground command relay decoder
// Assumes: 100 MHz clk, APB register access
// Notes: timing figures kept in their own units, cycle counts derived
`default_nettype none
package gcrd_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MSG_BITS = 12;
  localparam int unsigned SUBBITS = 5;
  localparam int unsigned SR_STAGES = 24;
  localparam int unsigned RELAYS = 24;
  // figures in their own units
  localparam int unsigned RESP_MS = 100;
  localparam int unsigned COIL_US = 20;
  localparam int unsigned GAP_US = 1000;
  localparam int unsigned RESP_CYCLES = RESP_MS * 1000 * CLK_MHZ;
  localparam int unsigned COIL_CYCLES = COIL_US * CLK_MHZ;
  localparam int unsigned GAP_CYCLES = GAP_US * CLK_MHZ;
  // apb byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CODES = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RELAYS = 8'h0c;
  localparam logic [7:0] OFS_COUNTS = 8'h10;
  // ctrl and status fields
  localparam int unsigned CTRL_VADDR_LSB = 0;
  localparam int unsigned CTRL_SADDR_LSB = 3;
  localparam int unsigned CTRL_EN_BIT = 6;
  localparam int unsigned STAT_ERR_BIT = 7;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0045;
  localparam logic [19:0] CODES_RST = 20'h3c1e0;
  localparam logic [23:0] RELAY_RST = 24'h00_0000;
  // relays that wait for an execution command
  localparam logic [23:0] DEFERRED_MASK = 24'h1c_1ffd;
  localparam logic [4:0] CH_EXEC_A = 5'h0f;
  localparam logic [4:0] CH_EXEC_B = 5'h12;
  localparam logic [4:0] CH_PATH_SEL = 5'h10;
  localparam logic [4:0] CH_LAST = 5'h18;
  typedef enum logic [1:0]
  {
    GCRD_IDLE = 2'b00,
    GCRD_RX = 2'b01,
    GCRD_COIL = 2'b10,
    GCRD_WAIT = 2'b11
  } gcrd_state_t;
endpackage
`default_nettype wire

// *** rtl/gcrd_top.sv ***
// Purpose: ground command decoder driving 24 latching relays
// Assumes: sub-bit strobes and phases synchronous to clk, synchronous reset
// Notes: only the real-time system address is handled; others are dropped
//
// Chosen here: the register offsets and the APB interface to the registers.
`default_nettype none
module gcrd_top
  import gcrd_pkg::*;
#(
  parameter int unsigned RESP_CYC = gcrd_pkg::RESP_CYCLES,
  parameter int unsigned GAP_CYC = gcrd_pkg::GAP_CYCLES
)
(
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // sync reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic rx_ok_a, // receiver a delivers signal
  input wire logic rx_strobe_a, // receiver a sub-bit strobe
  input wire logic rx_ref_a, // receiver a reference phase
  input wire logic rx_info_a, // receiver a information phase
  input wire logic rx_ok_b, // receiver b delivers signal
  input wire logic rx_strobe_b, // receiver b sub-bit strobe
  input wire logic rx_ref_b, // receiver b reference phase
  input wire logic rx_info_b, // receiver b information phase
  input wire logic supply_ok, // supply voltages in tolerance
  input wire logic func_ack, // addressed function responded
  output logic [23:0] coil_sel, // one-hot coil drive
  output logic coil_polarity, // common coil polarity, 1 set
  output logic [23:0] relay_state, // latched relay contacts
  output logic [1:0] pulse_bus, // execute line, [0] primary
  output logic [23:0] armed_fire, // deferred functions firing
  output logic verify // verification pulse to telemetry
);
  import gcrd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // receiver choice and sub-bit detection
  logic use_a;
  logic strobe;
  logic subbit;
  assign use_a = rx_ok_a;
  assign strobe = use_a ? rx_strobe_a : (rx_ok_b & rx_strobe_b);
  assign subbit = use_a ? ~(rx_info_a ^ rx_ref_a) : ~(rx_info_b ^ rx_ref_b);

  gcrd_state_t state_q;
  gcrd_state_t state_d;
  logic [31:0] ctrl_q;
  logic [19:0] codes_q;
  logic err_q;
  logic [15:0] acc_cnt_q;
  logic [15:0] err_cnt_q;
  logic [3:0] sub_sr_q;
  logic [2:0] sub_cnt_q;
  logic [23:0] msg_sr_q;
  logic [3:0] bit_cnt_q;
  logic addr_ok_q;
  logic [31:0] gap_cnt_q;
  logic [31:0] tmr_q;
  logic set_bit_q;
  logic [4:0] chan_q;
  logic [23:0] coil_q;
  logic pol_q;
  logic [23:0] relay_q;
  logic [1:0] pbus_q;
  logic [23:0] fire_q;
  logic verify_q;

  logic [4:0] code;
  logic [4:0] one_code;
  logic [4:0] zero_code;
  logic code_ok;
  logic bit_val;
  logic sync;
  logic [23:0] sr_next;
  logic gap_err;
  logic vaddr_bad;
  logic saddr_bad;
  logic cmd_ok;
  logic accept;
  logic timing_err;
  logic abort;

  assign code = {sub_sr_q, subbit};
  // header and message parts use different accepted codes
  assign one_code = addr_ok_q ? codes_q[14:10] : codes_q[4:0];
  assign zero_code = addr_ok_q ? codes_q[19:15] : codes_q[9:5];
  assign code_ok = (code == one_code) || (code == zero_code);
  assign bit_val = (code == one_code);
  // message start aligns the sub-bit counter; one sync per five strobes
  assign sync = strobe && (sub_cnt_q == 3'(SUBBITS - 1)) && (state_q == GCRD_RX);
  assign sr_next = {msg_sr_q[22:0], bit_val};
  assign gap_err = (state_q == GCRD_RX) && !strobe && (gap_cnt_q >= GAP_CYC - 1);
  assign vaddr_bad = sync && (bit_cnt_q == 4'd2) &&
    (sr_next[2:0] != ctrl_q[CTRL_VADDR_LSB +: 3]);
  assign saddr_bad = sync && (bit_cnt_q == 4'd5) &&
    (sr_next[2:0] != ctrl_q[CTRL_SADDR_LSB +: 3]);
  assign cmd_ok = (sr_next[5:1] != 5'h00) && (sr_next[5:1] <= CH_LAST);
  assign accept = sync && code_ok && (bit_cnt_q == 4'(MSG_BITS - 1)) && cmd_ok;
  assign timing_err = (sync && !code_ok) || gap_err;
  assign abort = !supply_ok || !ctrl_q[CTRL_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      GCRD_IDLE:
        if (strobe)
          state_d = GCRD_RX;
      GCRD_RX:
        if (timing_err || vaddr_bad || saddr_bad)
          state_d = GCRD_IDLE;
        else if (sync && bit_cnt_q == 4'(MSG_BITS - 1))
          state_d = cmd_ok ? GCRD_COIL : GCRD_IDLE;
      GCRD_COIL:
        if (tmr_q == 32'(COIL_CYCLES - 1))
          state_d = GCRD_WAIT;
      GCRD_WAIT:
        if (func_ack || tmr_q == RESP_CYC - 1)
          state_d = GCRD_IDLE;
      default:
        state_d = GCRD_IDLE;
    endcase
    if (abort)
      state_d = GCRD_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= GCRD_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sub-bit buffer and counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sub_sr_q <= 4'h0;
      sub_cnt_q <= 3'h0;
    end
    else if (state_q == GCRD_IDLE && !(strobe && !abort))
    begin
      sub_cnt_q <= 3'h0;
    end
    else if (strobe)
    begin
      sub_sr_q <= code[3:0];
      sub_cnt_q <= (sub_cnt_q == 3'(SUBBITS - 1)) ? 3'h0 : sub_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_q != GCRD_RX || strobe)
      gap_cnt_q <= 32'h0;
    else
      gap_cnt_q <= gap_cnt_q + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // message register, gated only by the sync pulse
  always_ff @(posedge clk)
  begin
    if (rst)
      msg_sr_q <= 24'h00_0000;
    else if (sync)
      msg_sr_q <= sr_next;
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_q == GCRD_IDLE)
    begin
      bit_cnt_q <= 4'h0;
      addr_ok_q <= 1'b0;
    end
    else if (sync)
    begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q == 4'd2 && !vaddr_bad)
        addr_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      set_bit_q <= 1'b0;
      chan_q <= 5'h00;
    end
    else if (accept)
    begin
      set_bit_q <= sr_next[0];
      chan_q <= sr_next[5:1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_q != state_d)
      tmr_q <= 32'h0;
    else
      tmr_q <= tmr_q + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // coil drive, latching relays, pulse line
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coil_q <= 24'h00_0000;
      pol_q <= 1'b0;
    end
    else if (state_d == GCRD_COIL)
    begin
      coil_q <= accept ? 24'h00_0001 << (sr_next[5:1] - 5'h01) : coil_q;
      pol_q <= accept ? sr_next[0] : pol_q;
    end
    else
    begin
      coil_q <= 24'h00_0000;
      pol_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      relay_q <= RELAY_RST;
    else if (accept && !abort)
      relay_q[sr_next[5:1] - 5'h01] <= sr_next[0];
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_d != GCRD_COIL)
    begin
      pbus_q <= 2'b00;
      fire_q <= 24'h00_0000;
    end
    // decode from the arriving message: chan_q still holds the previous command here
    else if (accept && (sr_next[5:1] == CH_EXEC_A || sr_next[5:1] == CH_EXEC_B) && sr_next[0])
    begin
      // channel 16 contact picks the execute path
      pbus_q <= relay_q[CH_PATH_SEL - 5'h01] ? 2'b10 : 2'b01;
      fire_q <= relay_q & DEFERRED_MASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      verify_q <= 1'b0;
    else
      verify_q <= (state_q == GCRD_COIL) && (state_d == GCRD_WAIT);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CODES) || (paddr == OFS_STATUS) ||
    (paddr == OFS_RELAYS) || (paddr == OFS_COUNTS);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= 32'h0;
      if (psel && penable && !pready && !pwrite)
      begin
        case (paddr)
          OFS_CTRL: prdata <= ctrl_q;
          OFS_CODES: prdata <= {12'h000, codes_q};
          OFS_STATUS: prdata <= {24'h00_0000, err_q, bit_cnt_q, addr_ok_q, state_q};
          OFS_RELAYS: prdata <= {8'h00, relay_q};
          OFS_COUNTS: prdata <= {err_cnt_q, acc_cnt_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RST;
      codes_q <= CODES_RST;
    end
    else if (wr && paddr == OFS_CTRL)
      ctrl_q <= {25'h0, pwdata[6:0]};
    else if (wr && paddr == OFS_CODES)
      codes_q <= pwdata[19:0];
  end

  // error flag: set wins over the write-one clear
  always_ff @(posedge clk)
  begin
    if (rst)
      err_q <= 1'b0;
    else if (state_q == GCRD_RX && timing_err)
      err_q <= 1'b1;
    else if (wr && paddr == OFS_STATUS && pwdata[STAT_ERR_BIT])
      err_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_cnt_q <= 16'h0;
      err_cnt_q <= 16'h0;
    end
    else
    begin
      if (accept && !abort)
        acc_cnt_q <= acc_cnt_q + 16'h1;
      if (state_q == GCRD_RX && timing_err)
        err_cnt_q <= err_cnt_q + 16'h1;
    end
  end

  assign coil_sel = coil_q;
  assign coil_polarity = pol_q;
  assign relay_state = relay_q;
  assign pulse_bus = pbus_q;
  assign armed_fire = fire_q;
  assign verify = verify_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_accept;
    accept && !abort;
  endsequence
  sequence s_coil_end;
    state_q == GCRD_COIL && state_d == GCRD_WAIT;
  endsequence

  a_vehicle_mismatch: assert property (vaddr_bad && state_q == GCRD_RX |=>
    state_q == GCRD_IDLE && coil_sel == 24'h0)
    else $error("vehicle mismatch did not discard");
  a_coil_onehot: assert property (s_accept |=> $onehot(coil_sel) &&
    coil_sel[$past(sr_next[5:1]) - 5'h01])
    else $error("coil drive not the selected relay");
  a_coil_polarity: assert property (s_accept |=> coil_polarity == $past(sr_next[0]))
    else $error("coil polarity wrong");
  a_verify_pulse: assert property (s_coil_end |=> verify ##1 !verify)
    else $error("verify not a single pulse after coil");
  a_supply_idle: assert property (!supply_ok |=> state_q == GCRD_IDLE)
    else $error("bad supply did not idle");
  a_bad_code_idle: assert property (sync && !code_ok |=> state_q == GCRD_IDLE)
    else $error("invalid sub-bit code did not idle");
  a_resp_timeout: assert property (state_q == GCRD_WAIT && tmr_q == RESP_CYC - 1 |=>
    state_q == GCRD_IDLE)
    else $error("response timeout did not idle");
  a_relay_hold: assert property (!(accept && !abort) |=> $stable(relay_state))
    else $error("relay changed without command");
  a_sync_gate: assert property (!sync |=> $stable(msg_sr_q))
    else $error("message register moved without sync");
  a_exec_pulse: assert property (s_accept ##1 (chan_q == CH_EXEC_A && set_bit_q) |=>
    pulse_bus != 2'b00)
    else $error("execute channel did not drive pulse line");
endmodule // gcrd_top
`default_nettype wire

// *** verification/gcrd_tx_model.sv ***
// Purpose: ground transmitter model sending phase-keyed sub-bits
// Assumes: sub-bit codes at their reset values
// Notes: phases wander when idle so stale values never look valid
`default_nettype none
module gcrd_tx_model
  import gcrd_pkg::*;
(
  input wire logic clk, // bench clock
  output var logic stb, // sub-bit strobe
  output var logic ref_ph, // reference phase
  output var logic info_ph // information phase
);
  timeunit 1ns;
  timeprecision 1ps;
  bit busy = 1'b0;
  initial stb = 1'b0;
  always @(posedge clk)
  begin
    if (!busy)
    begin
      ref_ph <= 1'($urandom);
      info_ph <= 1'($urandom);
    end
  end
  ////////////////////////////////////////
  // msg[11] goes first; cut below 60 stops mid-message
  task automatic send(input logic [11:0] msg, input int gmax, input int cut);
    logic [4:0] code;
    logic r;
    int n;
    n = 0;
    busy = 1'b1;
    for (int b = 11; b >= 0; b--)
    begin
      if (b >= 9)
        code = msg[b] ? CODES_RST[4:0] : CODES_RST[9:5];
      else
        code = msg[b] ? CODES_RST[14:10] : CODES_RST[19:15];
      for (int k = 4; k >= 0; k--)
      begin
        if (n < cut)
        begin
          r = 1'($urandom);
          stb <= 1'b1;
          ref_ph <= r;
          info_ph <= code[k] ? r : ~r;
          @(posedge clk);
          stb <= 1'b0;
          repeat ($urandom_range(gmax, 1))
          begin
            ref_ph <= 1'($urandom);
            info_ph <= 1'($urandom);
            @(posedge clk);
          end
        end
        n++;
      end
    end
    busy = 1'b0;
  endtask
endmodule // gcrd_tx_model
`default_nettype wire

// *** verification/tb_gcrd_top.sv ***
// Purpose: self-checking bench for the ground command decoder
// Assumes: short response and gap limits set through parameters
// Notes: driver queues relay results, a monitor checks them
`default_nettype none
module tb_gcrd_top
  import gcrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RESP = 200;
  localparam int GAP = 100;
  localparam logic [2:0] VA = CTRL_RST[2:0];
  typedef struct packed
  {
    logic [23:0] coil;
    logic pol;
    logic [23:0] rel;
    logic [1:0] pb;
    logic [23:0] af;
  } gcrd_note_t;
  logic clk, rst, psel, penable, pwrite, func_ack, supply_ok, ok_a, use_b, nz_r, nz_i;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, verify, coil_polarity, t_stb, t_ref, t_info;
  logic [23:0] coil_sel, relay_state, armed_fire, rel_m;
  logic [1:0] pulse_bus;
  gcrd_note_t notes[$];
  gcrd_note_t cur;
  bit in_coil = 1'b0;
  bit en_m = 1'b1;
  int coil_len = 0;
  int num_errors = 0;
  int comparisons = 0;
  int n_ok = 0;
  gcrd_top #(.RESP_CYC(RESP), .GAP_CYC(GAP)) DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_ok_a(ok_a), .rx_ok_b(use_b),
    .rx_strobe_a(use_b ? 1'b0 : t_stb), .rx_ref_a(use_b ? nz_r : t_ref),
    .rx_info_a(use_b ? nz_i : t_info), .rx_strobe_b(use_b ? t_stb : 1'b0),
    .rx_ref_b(use_b ? t_ref : nz_r), .rx_info_b(use_b ? t_info : nz_i),
    .supply_ok(supply_ok), .func_ack(func_ack), .coil_sel(coil_sel),
    .coil_polarity(coil_polarity), .relay_state(relay_state), .pulse_bus(pulse_bus),
    .armed_fire(armed_fire), .verify(verify));
  gcrd_tx_model tx (.clk(clk), .stb(t_stb), .ref_ph(t_ref), .info_ph(t_info));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    nz_r <= 1'($urandom);
    nz_i <= 1'($urandom);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no fixed wait count; only the watchdog ends a hung access
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] va, input logic [4:0] ch, input logic s,
                     input bit ack, input int gmax);
    gcrd_note_t n;
    logic [31:0] rd;
    logic er;
    bit ok;
    ok = en_m && va == VA && ch >= 1 && ch <= 24;
    if (ok)
    begin
      n.coil = 24'h1 << (ch - 1);
      rel_m = s ? (rel_m | n.coil) : (rel_m & ~n.coil);
      n.pol = s;
      n.rel = rel_m;
      n.pb = (s && (ch == CH_EXEC_A || ch == CH_EXEC_B)) ? (rel_m[15] ? 2'b10 : 2'b01) : 2'b00;
      n.af = (n.pb != 2'b00) ? (rel_m & DEFERRED_MASK) : 24'h0;
      notes.push_back(n);
      n_ok++;
    end
    tx.send({va, CTRL_RST[5:3], ch, s}, gmax, 60);
    if (ok)
    begin
      for (int i = 0; i < 3000 && verify !== 1'b1; i++)
        @(posedge clk);
      chk(verify, 1);
      if (ack)
        func_ack <= 1'b1;
      @(posedge clk);
      func_ack <= 1'b0;
      repeat (5) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk(rd[1:0], ack ? GCRD_IDLE : GCRD_WAIT);
    end
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      if (rd[1:0] == 2'b00)
        break;
    end
    chk(rd[1:0], GCRD_IDLE);
  endtask
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    if (in_coil)
      coil_len <= coil_len + 1;
    if (!rst && coil_sel !== 24'h0 && !in_coil)
    begin
      in_coil <= 1'b1;
      coil_len <= 0;
      chk(notes.size() > 0, 1);
      cur = notes.pop_front();
      chk(coil_sel, cur.coil);
      chk(coil_polarity, cur.pol);
      chk(relay_state, cur.rel);
      chk(pulse_bus, cur.pb);
      chk(armed_fire, cur.af);
    end
    if (!rst && verify === 1'b1)
    begin
      chk(in_coil, 1);
      chk(coil_len, COIL_CYCLES - 1);
      in_coil <= 1'b0;
    end
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial
  begin
    logic [31:0] rd;
    logic er;
    {psel, penable, pwrite, func_ack, use_b, paddr, pwdata} = '0;
    {rst, supply_ok, ok_a} = 3'b111;
    rel_m = 24'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'hca8fd76c));
    apb(1'b0, OFS_CTRL, 32'h0, rd, er);
    chk(rd, CTRL_RST);
    apb(1'b0, OFS_CODES, 32'h0, rd, er);
    chk(rd, {12'h0, CODES_RST});
    apb(1'b1, OFS_RELAYS, 32'hff_ffff, rd, er);
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk(er, 1);
    cmd(VA, CH_PATH_SEL, 1'b0, 1'b1, 4);
    cmd(VA, 5'd1, 1'b1, 1'b1, 4);
    cmd(VA, CH_EXEC_A, 1'b1, 1'b0, 4);
    cmd(VA, CH_PATH_SEL, 1'b1, 1'b1, 4);
    cmd(VA, CH_EXEC_B, 1'b1, 1'b1, 4);
    cmd(VA, CH_LAST, 1'b1, 1'b1, 4);
    for (int i = 0; i < 8; i++)
    begin
      use_b <= i[0];
      ok_a <= ~i[0];
      cmd(VA, 5'($urandom_range(24, 1)), 1'($urandom), 1'($urandom), $urandom_range(40, 1));
    end
    use_b <= 1'b0;
    ok_a <= 1'b1;
    cmd(VA, 5'd0, 1'b1, 1'b1, 4);
    cmd(VA, 5'd25, 1'b1, 1'b1, 4);
    cmd(3'd3, 5'd2, 1'b1, 1'b1, 4);
    // foreign system address: no coil may follow, leftovers end in idle
    tx.send({VA, 3'd1, 5'd2, 1'b1}, 4, 60);
    repeat (GAP + 20) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    chk(rd[1:0], GCRD_IDLE);
    apb(1'b1, OFS_CTRL, 32'h05, rd, er);
    en_m = 1'b0;
    cmd(VA, 5'd2, 1'b1, 1'b1, 4);
    en_m = 1'b1;
    apb(1'b1, OFS_CTRL, CTRL_RST, rd, er);
    apb(1'b0, OFS_RELAYS, 32'h0, rd, er);
    chk(rd, {8'h0, rel_m});
    apb(1'b0, OFS_COUNTS, 32'h0, rd, er);
    chk(rd[15:0], n_ok);
    apb(1'b1, OFS_STATUS, 32'h80, rd, er);
    tx.send({VA, 3'd0, 5'd2, 1'b1}, 4, 30);
    supply_ok <= 1'b0;
    @(posedge clk);
    supply_ok <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    chk({rd[7], rd[1:0]}, 3'b000);
    tx.send({VA, 3'd0, 5'd2, 1'b1}, 4, 30);
    repeat (GAP + 20) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    chk({rd[7], rd[1:0]}, 3'b100);
    repeat (10) @(posedge clk);
    chk(notes.size(), 0);
    end_sim();
  end
endmodule // tb_gcrd_top
`default_nettype wire
